/* File: dac_update_pkg.sv */
// constants and types shared by the update-control design
package dac_update_pkg;

  // frame layout
  localparam int FRAME_W   = 24;
  localparam int CMD_MSB   = 23;
  localparam int CMD_LSB   = 20;
  localparam int ADDR_MSB  = 19;
  localparam int ADDR_LSB  = 16;
  localparam int DATA_MSB  = 15;
  localparam int DATA_LSB  = 0;
  localparam int MASK_MSB  = 3;

  // channel geometry
  localparam int NUM_CH    = 4;
  localparam int CODE_W    = 16;
  localparam int MASK_W    = 4;
  localparam int SYNC_W    = 3;

  // command codes
  localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
  localparam logic [3:0] CMD_UPDATE       = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_LOAD_MASK    = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;

  // reset values and clear codes
  localparam logic [MASK_W-1:0] LOAD_MASK_RESET = 4'h0;
  localparam logic [CODE_W-1:0] ZERO_SCALE      = 16'h0000;
  localparam logic [CODE_W-1:0] MID_SCALE       = 16'h8000;
  localparam logic [FRAME_W-1:0] FRAME_RESET    = 24'h000000;

  // synchroniser bit positions
  localparam int SYNC_STROBE = 0;
  localparam int SYNC_HWRST  = 1;
  localparam int SYNC_CLRSEL = 2;

  // timing
  localparam int REF_CLK_MHZ = 100;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES  = (POR_TIME_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int POR_CNT_W   = 8;
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [POR_CNT_W-1:0] POR_ZERO = 8'h00;
  localparam logic [POR_CNT_W-1:0] POR_ONE  = 8'h01;

  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_RUN   = 2'b01,
    ST_HWRST = 2'b10
  } ctrl_state_t;

endpackage : dac_update_pkg

/* File: frame_if.sv */
// carrier for a latched 24-bit frame between receiver and update logic
`timescale 1ns/1ps
interface frame_if;
  logic                                valid;
  logic [dac_update_pkg::FRAME_W-1:0]  word;

  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface : frame_if

/* File: pin_sync.sv */
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output      logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : pin_sync

/* File: frame_rx.sv */
// serial frame shifter on the link clock, handed over at frame-select rise
`timescale 1ns/1ps
module frame_rx (
  // reference domain
  input  wire logic  clk,
  input  wire logic  rst,
  // link domain
  input  wire logic  link_clk,
  input  wire logic  frame_sel_n,
  input  wire logic  serial_data,
  // latched frames
  frame_if.src       frm
);
  logic [dac_update_pkg::FRAME_W-1:0] shift_reg;
  logic                               sel_meta_reg;
  logic                               sel_sync_reg;
  logic                               sel_prev_reg;

  // link domain: shift while frame select low
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= dac_update_pkg::FRAME_RESET;
    end else if (!frame_sel_n) begin
      shift_reg <= {shift_reg[dac_update_pkg::FRAME_W-2:0], serial_data};
    end
  end

  // frame select level into reference domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
    end else begin
      sel_meta_reg <= frame_sel_n;
      sel_sync_reg <= sel_meta_reg;
      sel_prev_reg <= sel_sync_reg;
    end
  end

  // word is stable while select stays high, so sample it after the rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frm.valid <= 1'b0;
      frm.word  <= dac_update_pkg::FRAME_RESET;
    end else begin
      frm.valid <= sel_sync_reg & ~sel_prev_reg;
      if (sel_sync_reg & ~sel_prev_reg) begin
        frm.word <= shift_reg;
      end
    end
  end
endmodule : frame_rx

/* File: dac_update_control.sv */
// update path of a four-channel double-buffered serial DAC
`timescale 1ns/1ps

// Overview of operation
// - load-mask command stores data bits 3..0
// - mask clears to zero at reset
// - masked channel ignores the load strobe falling edge
// - write-input updates DAC only with strobe low
// - update command copies input to DAC
// - write-and-update loads both registers whatever the strobe level
// - strobe falling edge updates unmasked channels
// - strobe held low overrides the mask
// - reset pin clears to zero or midscale
// - reset low blocks updates, cleared value holds
// - software reset restores power-on code
// - strobe and reset pin ignored during power-on
// - power-up level chosen by clear-level select
// - 24-bit word taken at frame-select rise
// - write-input with strobe low updates at rise
module dac_update_control (
  // clock and power-on reset
  input  wire logic                                          REF_CLK,
  input  wire logic                                          RESET,
  // serial link
  input  wire logic                                          SERIAL_CLK,
  input  wire logic                                          FRAME_SEL_N,
  input  wire logic                                          SERIAL_DATA,
  // control pins
  input  wire logic                                          LOAD_UPDATE_STROBE_N,
  input  wire logic                                          HW_RESET_N,
  input  wire logic                                          CLEAR_LEVEL_SELECT,
  // channel state
  output wire logic [dac_update_pkg::NUM_CH-1:0][dac_update_pkg::CODE_W-1:0] DAC_CODE,
  output wire logic [dac_update_pkg::NUM_CH-1:0][dac_update_pkg::CODE_W-1:0] INPUT_CODE,
  output      logic [dac_update_pkg::MASK_W-1:0]             LOAD_MASK,
  output      logic                                          POR_BUSY
);

  // clear code for a select level
  function automatic logic [dac_update_pkg::CODE_W-1:0] clear_code(input logic sel);
    clear_code = sel ? dac_update_pkg::MID_SCALE : dac_update_pkg::ZERO_SCALE;
  endfunction : clear_code

  // command field of a frame
  function automatic logic [3:0] cmd_of(input logic [dac_update_pkg::FRAME_W-1:0] w);
    cmd_of = w[dac_update_pkg::CMD_MSB:dac_update_pkg::CMD_LSB];
  endfunction : cmd_of

  // match of a command field against one code
  function automatic logic cmd_is(input logic [3:0] c, input logic [3:0] code);
    cmd_is = (c == code);
  endfunction : cmd_is

  frame_if frm ();

  logic [dac_update_pkg::SYNC_W-1:0]   pins_sync;
  logic                                strobe_prev_reg;
  logic                                strobe_fall;
  logic                                strobe_low;
  logic                                hwrst_low;
  logic                                clr_sel;
  dac_update_pkg::ctrl_state_t         state_reg;
  dac_update_pkg::ctrl_state_t         state_next;
  logic [dac_update_pkg::POR_CNT_W-1:0] por_cnt_reg;
  logic [dac_update_pkg::CODE_W-1:0]   por_code_reg;
  logic [dac_update_pkg::MASK_W-1:0]   mask_reg;
  logic [3:0]                          cmd;
  logic [dac_update_pkg::NUM_CH-1:0]   addr;
  logic [dac_update_pkg::CODE_W-1:0]   data;
  logic                                run;
  logic                                soft_rst;
  logic                                take;
  logic                                do_mask;
  logic [dac_update_pkg::NUM_CH-1:0]   hit_vec;
  logic [dac_update_pkg::NUM_CH-1:0]   edge_copy;
  logic [dac_update_pkg::CODE_W-1:0]   clear_code_reg;

  frame_rx u_rx (
    .clk         (REF_CLK),
    .rst         (RESET),
    .link_clk    (SERIAL_CLK),
    .frame_sel_n (FRAME_SEL_N),
    .serial_data (SERIAL_DATA),
    .frm         (frm.src)
  );

  pin_sync #(.W(dac_update_pkg::SYNC_W)) u_sync (
    .clk      (REF_CLK),
    .rst      (RESET),
    .async_in ({CLEAR_LEVEL_SELECT, HW_RESET_N, LOAD_UPDATE_STROBE_N}),
    .sync_out (pins_sync)
  );

  assign strobe_low = ~pins_sync[dac_update_pkg::SYNC_STROBE];
  assign hwrst_low  = ~pins_sync[dac_update_pkg::SYNC_HWRST];
  assign clr_sel    = pins_sync[dac_update_pkg::SYNC_CLRSEL];
  assign strobe_fall = strobe_prev_reg & strobe_low;

  assign cmd      = cmd_of(frm.word);
  assign addr     = frm.word[dac_update_pkg::ADDR_MSB:dac_update_pkg::ADDR_LSB];
  assign data     = frm.word[dac_update_pkg::DATA_MSB:dac_update_pkg::DATA_LSB];
  assign run      = (state_reg == dac_update_pkg::ST_RUN);

  // frames act only while running with the reset pin high
  assign take     = run & frm.valid & ~hwrst_low;
  assign soft_rst = take & cmd_is(cmd, dac_update_pkg::CMD_SOFT_RESET);
  assign do_mask  = take & cmd_is(cmd, dac_update_pkg::CMD_LOAD_MASK);
  assign hit_vec  = take ? addr : '0;

  // masked channels never see a strobe falling edge
  generate
    for (genvar m = 0; m < dac_update_pkg::NUM_CH; m++) begin : g_mask
      assign edge_copy[m] = strobe_fall & ~mask_reg[m];
    end
  endgenerate

  // one registered clear code so all channels switch together
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      clear_code_reg <= dac_update_pkg::ZERO_SCALE;
    end else begin
      clear_code_reg <= clear_code(clr_sel);
    end
  end

  // strobe history for edge detection
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= ~strobe_low;
    end
  end

  // control state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dac_update_pkg::ST_POR: begin
        if (por_cnt_reg == dac_update_pkg::POR_LAST) begin
          state_next = dac_update_pkg::ST_RUN;
        end
      end
      dac_update_pkg::ST_RUN: begin
        if (hwrst_low) begin
          state_next = dac_update_pkg::ST_HWRST;
        end
      end
      dac_update_pkg::ST_HWRST: begin
        if (!hwrst_low) begin
          state_next = dac_update_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = dac_update_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= dac_update_pkg::ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // power-on interval counter
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      por_cnt_reg <= dac_update_pkg::POR_ZERO;
    end else if (state_reg == dac_update_pkg::ST_POR) begin
      por_cnt_reg <= por_cnt_reg + dac_update_pkg::POR_ONE;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      POR_BUSY <= 1'b1;
    end else begin
      POR_BUSY <= (state_next == dac_update_pkg::ST_POR);
    end
  end

  // power-on code follows the select pin until the interval ends
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      por_code_reg <= dac_update_pkg::ZERO_SCALE;
    end else if (state_reg == dac_update_pkg::ST_POR) begin
      por_code_reg <= clear_code_reg;
    end
  end

  // load-mask register
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      mask_reg <= dac_update_pkg::LOAD_MASK_RESET;
    end else if (do_mask) begin
      mask_reg <= data[dac_update_pkg::MASK_MSB:0];
    end
  end

  assign LOAD_MASK = mask_reg;

  // per-channel input and DAC registers
  generate
    for (genvar ch = 0; ch < dac_update_pkg::NUM_CH; ch++) begin : g_ch
      logic [dac_update_pkg::CODE_W-1:0] input_reg;
      logic [dac_update_pkg::CODE_W-1:0] input_next;
      logic [dac_update_pkg::CODE_W-1:0] dac_reg;
      logic [dac_update_pkg::CODE_W-1:0] dac_next;
      logic                              hit;

      assign hit = hit_vec[ch];

      always_comb begin
        input_next = input_reg;
        dac_next   = dac_reg;
        case (state_reg)
          dac_update_pkg::ST_POR: begin
            input_next = clear_code_reg;
            dac_next   = clear_code_reg;
          end
          dac_update_pkg::ST_HWRST: begin
            input_next = clear_code_reg;
            dac_next   = clear_code_reg;
          end
          dac_update_pkg::ST_RUN: begin
            if (hwrst_low) begin
              input_next = clear_code_reg;
              dac_next   = clear_code_reg;
            end else if (soft_rst) begin
              input_next = por_code_reg;
              dac_next   = por_code_reg;
            end else begin
              // edge update uses the input value held before this cycle
              if (edge_copy[ch]) begin
                dac_next = input_reg;
              end
              if (hit) begin
                case (cmd)
                  dac_update_pkg::CMD_WRITE_INPUT: begin
                    input_next = data;
                    if (strobe_low) begin
                      dac_next = data;
                    end
                  end
                  dac_update_pkg::CMD_UPDATE: begin
                    dac_next = input_reg;
                  end
                  dac_update_pkg::CMD_WRITE_UPDATE: begin
                    input_next = data;
                    dac_next   = data;
                  end
                  default: begin
                    input_next = input_reg;
                  end
                endcase
              end
            end
          end
          default: begin
            dac_next = dac_reg;
          end
        endcase
      end

      always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
          input_reg <= dac_update_pkg::ZERO_SCALE;
        end else begin
          input_reg <= input_next;
        end
      end

      always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
          dac_reg <= dac_update_pkg::ZERO_SCALE;
        end else begin
          dac_reg <= dac_next;
        end
      end

      assign DAC_CODE[ch]   = dac_reg;
      assign INPUT_CODE[ch] = input_reg;
    end
  endgenerate

endmodule : dac_update_control

/* File: dac_update_control_assertions.sv */
// concurrent checks on the update-control ports
`timescale 1ns/1ps
module dac_update_control_assertions (
  // clock and reset
  input wire logic                                                  REF_CLK,
  input wire logic                                                  RESET,
  // control pins
  input wire logic                                                  LOAD_UPDATE_STROBE_N,
  input wire logic                                                  HW_RESET_N,
  input wire logic                                                  CLEAR_LEVEL_SELECT,
  // channel state
  input wire logic [dac_update_pkg::NUM_CH-1:0][dac_update_pkg::CODE_W-1:0] DAC_CODE,
  input wire logic [dac_update_pkg::NUM_CH-1:0][dac_update_pkg::CODE_W-1:0] INPUT_CODE,
  input wire logic [dac_update_pkg::MASK_W-1:0]                     LOAD_MASK,
  input wire logic                                                  POR_BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  logic [15:0] clr;
  logic [7:0]  por_cnt;
  assign clr = CLEAR_LEVEL_SELECT ? dac_update_pkg::MID_SCALE : dac_update_pkg::ZERO_SCALE;
  // length of the power-on interval
  always_ff @(posedge REF_CLK or posedge RESET)
    if (RESET) por_cnt <= 8'h00;
    else if (POR_BUSY) por_cnt <= por_cnt + 8'h01;
  sequence sel_quiet;
    $stable(CLEAR_LEVEL_SELECT)[*6];
  endsequence
  sequence hw_up;
    HW_RESET_N[*4];
  endsequence
  mask_reset_a: assert property ($fell(RESET) |-> LOAD_MASK == 4'h0)
    else $error("load mask not clear after reset");
  por_level_a: assert property (sel_quiet ##0 $fell(POR_BUSY) |-> DAC_CODE == {4{clr}} && INPUT_CODE == {4{clr}})
    else $error("power-up level wrong");
  por_hold_a: assert property ((POR_BUSY && $stable(CLEAR_LEVEL_SELECT))[*6] |-> $stable(DAC_CODE))
    else $error("update during power-on");
  por_len_a: assert property ($fell(POR_BUSY) |-> por_cnt inside {[8'h62:8'h66]})
    else $error("power-on interval length wrong");
  mask_guard_a: assert property ($changed(LOAD_MASK) |-> !POR_BUSY)
    else $error("mask changed during power-on");
  hw_clear_a: assert property ((!HW_RESET_N && $stable(CLEAR_LEVEL_SELECT))[*6] |-> DAC_CODE == {4{clr}})
    else $error("hardware reset clear code wrong");
  hw_hold_a: assert property (sel_quiet ##0 $rose(HW_RESET_N) |-> $stable(DAC_CODE)[*3])
    else $error("cleared value not held");
  strobe_copy_a: assert property (hw_up ##0 ($fell(LOAD_UPDATE_STROBE_N) && !LOAD_MASK[0] && !POR_BUSY)
    |-> ##[1:4] DAC_CODE[0] == INPUT_CODE[0]) else $error("strobe did not copy channel a");
  strobe_mask_a: assert property (hw_up ##0 ($fell(LOAD_UPDATE_STROBE_N) && LOAD_MASK[2] && !POR_BUSY)
    |-> $stable(DAC_CODE[2])[*5]) else $error("masked channel updated");
endmodule : dac_update_control_assertions

bind dac_update_control dac_update_control_assertions i_chk (.REF_CLK(REF_CLK), .RESET(RESET),
  .LOAD_UPDATE_STROBE_N(LOAD_UPDATE_STROBE_N), .HW_RESET_N(HW_RESET_N), .CLEAR_LEVEL_SELECT(CLEAR_LEVEL_SELECT),
  .DAC_CODE(DAC_CODE), .INPUT_CODE(INPUT_CODE), .LOAD_MASK(LOAD_MASK), .POR_BUSY(POR_BUSY));

/* File: host_link_model.sv */
// host side of the serial link sending whole frames
`timescale 1ns/1ps
module host_link_model (
  // link pins
  output logic sclk,
  output logic sel_n,
  output logic sdata
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdata = 1'b0;
  end
  // msb first, clock parked low outside frames
  task automatic send(input logic [23:0] w);
    sel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 sel_n = 1'b1;
    sdata = ~sdata;
    #100;
  endtask : send
endmodule : host_link_model

/* File: dac_update_control_tb.sv */
// self-checking bench for the update-control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module dac_update_control_tb;
  logic             ref_clk;
  logic             reset;
  logic             strobe_n;
  logic             hw_rst_n;
  logic             clr_sel;
  wire logic        sclk;
  wire logic        sel_n;
  wire logic        sdata;
  logic [3:0][15:0] dac;
  logic [3:0][15:0] inp;
  logic [3:0]       mask;
  logic             busy;
  int               error_cnt;
  int               total_checks;
  host_link_model i_host (.sclk(sclk), .sel_n(sel_n), .sdata(sdata));
  dac_update_control i_dut (.REF_CLK(ref_clk), .RESET(reset), .SERIAL_CLK(sclk), .FRAME_SEL_N(sel_n),
    .SERIAL_DATA(sdata), .LOAD_UPDATE_STROBE_N(strobe_n), .HW_RESET_N(hw_rst_n), .CLEAR_LEVEL_SELECT(clr_sel),
    .DAC_CODE(dac), .INPUT_CODE(inp), .LOAD_MASK(mask), .POR_BUSY(busy));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic frame(input logic [23:0] w);
    i_host.send(w);
    repeat (8) @(negedge ref_clk);
  endtask : frame
  task automatic pin(input logic v);
    @(negedge ref_clk);
    strobe_n = v;
    repeat (6) @(negedge ref_clk);
  endtask : pin
  task automatic t_power;
    int n = 0;
    @(negedge ref_clk);
    strobe_n = 1'b0;
    hw_rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    strobe_n = 1'b1;
    hw_rst_n = 1'b1;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("por_busy", 1'b0, busy)
    for (int c = 0; c < 4; c++) begin
      `CHK("dac", dac_update_pkg::MID_SCALE, dac[c])
    end
    `CHK("mask", dac_update_pkg::LOAD_MASK_RESET, mask)
    $display("test power done");
  endtask : t_power
  task automatic t_write;
    frame({dac_update_pkg::CMD_WRITE_INPUT, 4'h1, 16'h1234});
    `CHK("inp_a", 16'h1234, inp[0])
    `CHK("dac_a", dac_update_pkg::MID_SCALE, dac[0])
    frame({dac_update_pkg::CMD_UPDATE, 4'h1, 16'hFFFF});
    `CHK("dac_a", 16'h1234, dac[0])
    `CHK("inp_a", 16'h1234, inp[0])
    frame({dac_update_pkg::CMD_WRITE_UPDATE, 4'h2, 16'hABCD});
    `CHK("dac_b", 16'hABCD, dac[1])
    frame({dac_update_pkg::CMD_LOAD_MASK, 4'hF, 16'hFFF4});
    `CHK("mask", 4'h4, mask)
    pin(1'b0);
    frame({dac_update_pkg::CMD_WRITE_INPUT, 4'h4, 16'h0C0C});
    `CHK("dac_c", 16'h0C0C, dac[2])
    frame({dac_update_pkg::CMD_WRITE_UPDATE, 4'h8, 16'h0D0D});
    `CHK("dac_d", 16'h0D0D, dac[3])
    pin(1'b1);
    $display("test write done");
  endtask : t_write
  task automatic t_mask;
    frame({dac_update_pkg::CMD_WRITE_INPUT, 4'h5, 16'h5555});
    `CHK("dac_a", 16'h1234, dac[0])
    pin(1'b0);
    `CHK("dac_a", 16'h5555, dac[0])
    `CHK("dac_c", 16'h0C0C, dac[2])
    pin(1'b1);
    $display("test mask done");
  endtask : t_mask
  task automatic t_soft;
    frame({dac_update_pkg::CMD_SOFT_RESET, 4'hF, 16'h0000});
    `CHK("dac_b", dac_update_pkg::MID_SCALE, dac[1])
    `CHK("inp_a", dac_update_pkg::MID_SCALE, inp[0])
    `CHK("mask", 4'h4, mask)
    $display("test soft reset done");
  endtask : t_soft
  task automatic t_hwrst;
    @(negedge ref_clk);
    clr_sel = 1'b0;
    hw_rst_n = 1'b0;
    frame({dac_update_pkg::CMD_WRITE_UPDATE, 4'hF, 16'h7777});
    for (int c = 0; c < 4; c++) begin
      `CHK("dac", dac_update_pkg::ZERO_SCALE, dac[c])
    end
    hw_rst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    `CHK("dac_a", dac_update_pkg::ZERO_SCALE, dac[0])
    $display("test hardware reset done");
  endtask : t_hwrst
  task automatic t_por_zero;
    int n = 0;
    @(negedge ref_clk);
    clr_sel = 1'b0;
    reset = 1'b1;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    `CHK("por_busy", 1'b1, busy)
    while (busy !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    for (int c = 0; c < 4; c++) begin
      `CHK("dac", dac_update_pkg::ZERO_SCALE, dac[c])
      `CHK("inp", dac_update_pkg::ZERO_SCALE, inp[c])
    end
    `CHK("mask", dac_update_pkg::LOAD_MASK_RESET, mask)
    $display("test zero power-up done");
  endtask : t_por_zero
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #300000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    reset = 1'b1;
    strobe_n = 1'b1;
    hw_rst_n = 1'b1;
    clr_sel = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    t_power();
    t_write();
    t_mask();
    t_soft();
    t_hwrst();
    t_por_zero();
    tally_and_finish();
  end
endmodule : dac_update_control_tb
